// File: ltg_defs.vh
// ltg_defs.vh: constants for the lane-four threshold/gain register slice.
// assumes: included by bare name from every design file of this block.
`ifndef LTG_DEFS_VH
`define LTG_DEFS_VH

// ****************************************************************
// register offsets on the two-wire serial port
// ****************************************************************
`define LTG_OFF_LANE4_CTRL 8'h14
`define LTG_OFF_RSVD_A 8'h10
`define LTG_OFF_RSVD_B 8'h15
`define LTG_OFF_RSVD_C 8'h17
`define LTG_OFF_RSVD_D 8'h18
`define LTG_OFF_RSVD_E 8'h19

// ****************************************************************
// reset values
// ****************************************************************
`define LTG_RST_LANE4_CTRL 8'h00
`define LTG_RST_RESERVED 8'h00

// ****************************************************************
// field positions of the lane-four threshold/gain register
// ****************************************************************
`define LTG_BIT_LANE_SLEEP 7
`define LTG_BIT_DRIVER_OFF 6
`define LTG_BIT_ATTEN_HI 5
`define LTG_BIT_ATTEN_LO 4
`define LTG_BIT_OFFSET_SIGN 3
`define LTG_BIT_OFFSET_MSB 2
`define LTG_BIT_OFFSET_LSB 0

// ****************************************************************
// attenuation codes
// ****************************************************************
`define LTG_GAIN_DEFAULT 2'h0
`define LTG_GAIN_UNUSED 2'h1
`define LTG_GAIN_MEDIUM 2'h2
`define LTG_GAIN_MINIMUM 2'h3

// ****************************************************************
// serial port framing
// ****************************************************************
// device address: the value is arbitrary
`define LTG_DEV_ADDR 7'h2A
`define LTG_BITS_PER_BYTE 4'h8

`endif

// File: ltg_sync.v
// ltg_sync.v: two-flop synchroniser for one asynchronous level.
// assumes: input comes from a pin; output is read only on clk.
`timescale 1ns/1ns
`include "ltg_defs.vh"

module ltg_sync #(
    parameter RESET_VAL = 1'b0
) (
    input wire clk,
    input wire rstn,
    input wire async_in,
    output reg sync_out
);

    reg meta;

    // the first stage feeds nothing but the second stage
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= RESET_VAL;
            sync_out <= RESET_VAL;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule // ltg_sync

// File: ltg_regs.v
// ltg_regs.v: two-wire serial slave holding the lane-four threshold/gain
// register and the decoded lane controls; its reserved neighbours read as zero.
// assumes: scl and sda are pins from the host, sda is open drain and is
// resolved outside from sda_oe; swing_strap is a board strap pin.
`timescale 1ns/1ns
`include "ltg_defs.vh"

// How it works
// - bit 7 set puts lane four asleep
// - bit 6 set turns lane-four output driver off
// - gain bits: 00 default, 10 medium, 11 minimum
// - threshold bits decoded as sign and magnitude
// - control register at 14h, read/write, resets zero
// - 10h, 15h, 17h, 18h, 19h are reserved
// - lane sleep never stops the serial port
module ltg_regs #(
    parameter DEV_ADDR = `LTG_DEV_ADDR
) (
    input wire clk,
    input wire rstn,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire swing_strap,
    output reg lane_sleep,
    output reg output_driver_off,
    output reg gain_medium,
    output reg gain_minimum,
    output reg offset_positive,
    output reg offset_negative,
    output reg [2:0] offset_magnitude,
    output reg swing_full
);

    // ****************************************************************
    // states of the serial engine
    // ****************************************************************
    localparam [9:0] ST_IDLE = 10'h001;
    localparam [9:0] ST_ADDR = 10'h002;
    localparam [9:0] ST_ADDR_ACK = 10'h004;
    localparam [9:0] ST_OFFS = 10'h008;
    localparam [9:0] ST_OFFS_ACK = 10'h010;
    localparam [9:0] ST_WDATA = 10'h020;
    localparam [9:0] ST_WDATA_ACK = 10'h040;
    localparam [9:0] ST_RDATA = 10'h080;
    localparam [9:0] ST_RDATA_ACK = 10'h100;
    localparam [9:0] ST_IGNORE = 10'h200;

    wire [2:0] pin_raw;
    wire [2:0] pin_sync;
    wire scl_s;
    wire sda_s;
    wire strap_s;
    reg scl_q;
    reg sda_q;
    reg [9:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] rx_byte;
    reg [7:0] tx_byte;
    reg [7:0] offset;
    reg read_dir;
    reg host_nack;
    reg [7:0] lane4_ctrl;
    wire scl_rise;
    wire scl_fall;
    wire start_seen;
    wire stop_seen;
    wire byte_full;
    wire [7:0] next_offset;
    wire [7:0] rd_cur;
    wire [7:0] rd_step;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    assign pin_raw = {swing_strap, sda_in, scl_in};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_sync
            ltg_sync #(
                .RESET_VAL(1'b1)
            ) u_sync (
                .clk(clk),
                .rstn(rstn),
                .async_in(pin_raw[gi]),
                .sync_out(pin_sync[gi])
            );
        end
    endgenerate

    assign scl_s = pin_sync[0];
    assign sda_s = pin_sync[1];
    assign strap_s = pin_sync[2];

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function is_reserved;
        input [7:0] off;
        begin
            is_reserved = (off == `LTG_OFF_RSVD_A) || (off == `LTG_OFF_RSVD_B) ||
                          (off == `LTG_OFF_RSVD_C) || (off == `LTG_OFF_RSVD_D) ||
                          (off == `LTG_OFF_RSVD_E);
        end
    endfunction

    // reserved and foreign offsets read as zero; only 14h holds state
    function [7:0] read_mux;
        input [7:0] off;
        input [7:0] ctrl;
        begin
            if (is_reserved(off))
                read_mux = `LTG_RST_RESERVED;
            else if (off == `LTG_OFF_LANE4_CTRL)
                read_mux = ctrl;
            else
                read_mux = 8'h00;
        end
    endfunction

    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign start_seen = scl_s && scl_q && sda_q && !sda_s;
    assign stop_seen = scl_s && scl_q && !sda_q && sda_s;
    assign byte_full = (bit_cnt == `LTG_BITS_PER_BYTE);
    assign next_offset = offset + 8'h01;
    assign rd_cur = read_mux(offset, lane4_ctrl);
    assign rd_step = read_mux(next_offset, lane4_ctrl);

    // ****************************************************************
    // serial engine and register
    // ****************************************************************
    // the engine runs from the shared clock and reset only, so a sleeping
    // lane keeps its port reachable and can be woken again
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            rx_byte <= 8'h00;
            tx_byte <= 8'h00;
            offset <= 8'h00;
            read_dir <= 1'b0;
            host_nack <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            lane4_ctrl <= `LTG_RST_LANE4_CTRL;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            sda_out <= 1'b0;
            if (start_seen)
            begin
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
            end
            else if (stop_seen)
            begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
            end
            else if (scl_rise)
            begin
                case (state)
                    ST_ADDR, ST_OFFS, ST_WDATA:
                    begin
                        rx_byte <= {rx_byte[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    ST_RDATA:
                        bit_cnt <= bit_cnt + 4'h1;
                    ST_RDATA_ACK:
                        host_nack <= sda_s;
                    default:
                        bit_cnt <= bit_cnt;
                endcase
            end
            else if (scl_fall)
            begin
                case (state)
                    ST_ADDR:
                    begin
                        if (byte_full)
                        begin
                            bit_cnt <= 4'h0;
                            if (rx_byte[7:1] == DEV_ADDR)
                            begin
                                read_dir <= rx_byte[0];
                                sda_oe <= 1'b1;
                                state <= ST_ADDR_ACK;
                            end
                            else
                                state <= ST_IGNORE;
                        end
                    end
                    ST_ADDR_ACK:
                    begin
                        bit_cnt <= 4'h0;
                        if (read_dir)
                        begin
                            tx_byte <= rd_cur;
                            sda_oe <= ~rd_cur[7];
                            state <= ST_RDATA;
                        end
                        else
                        begin
                            sda_oe <= 1'b0;
                            state <= ST_OFFS;
                        end
                    end
                    ST_OFFS:
                    begin
                        if (byte_full)
                        begin
                            bit_cnt <= 4'h0;
                            offset <= rx_byte;
                            sda_oe <= 1'b1;
                            state <= ST_OFFS_ACK;
                        end
                    end
                    ST_OFFS_ACK, ST_WDATA_ACK:
                    begin
                        sda_oe <= 1'b0;
                        state <= ST_WDATA;
                    end
                    ST_WDATA:
                    begin
                        if (byte_full)
                        begin
                            bit_cnt <= 4'h0;
                            // reserved and foreign offsets are acked but dropped
                            if (offset == `LTG_OFF_LANE4_CTRL && !is_reserved(offset))
                                lane4_ctrl <= rx_byte;
                            offset <= next_offset;
                            sda_oe <= 1'b1;
                            state <= ST_WDATA_ACK;
                        end
                    end
                    ST_RDATA:
                    begin
                        if (byte_full)
                        begin
                            sda_oe <= 1'b0;
                            state <= ST_RDATA_ACK;
                        end
                        else
                            sda_oe <= ~tx_byte[3'h7 - bit_cnt[2:0]];
                    end
                    ST_RDATA_ACK:
                    begin
                        bit_cnt <= 4'h0;
                        if (host_nack)
                            state <= ST_IGNORE;
                        else
                        begin
                            offset <= next_offset;
                            tx_byte <= rd_step;
                            sda_oe <= ~rd_step[7];
                            state <= ST_RDATA;
                        end
                    end
                    ST_IDLE, ST_IGNORE:
                        sda_oe <= 1'b0;
                    default:
                    begin
                        sda_oe <= 1'b0;
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // decoded lane controls
    // ****************************************************************
    // registered so every output leaves a flop; one clock behind the field
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lane_sleep <= 1'b0;
            output_driver_off <= 1'b0;
            gain_medium <= 1'b0;
            gain_minimum <= 1'b0;
            offset_positive <= 1'b0;
            offset_negative <= 1'b0;
            offset_magnitude <= 3'h0;
            swing_full <= 1'b1;
        end
        else
        begin
            lane_sleep <= lane4_ctrl[`LTG_BIT_LANE_SLEEP];
            output_driver_off <= lane4_ctrl[`LTG_BIT_DRIVER_OFF];
            // code 01 has no defined gain, so it keeps the default gain
            case (lane4_ctrl[`LTG_BIT_ATTEN_HI:`LTG_BIT_ATTEN_LO])
                `LTG_GAIN_MEDIUM:
                begin
                    gain_medium <= 1'b1;
                    gain_minimum <= 1'b0;
                end
                `LTG_GAIN_MINIMUM:
                begin
                    gain_medium <= 1'b0;
                    gain_minimum <= 1'b1;
                end
                default:
                begin
                    gain_medium <= 1'b0;
                    gain_minimum <= 1'b0;
                end
            endcase
            // 0000 and 1000 are both zero shift: magnitude zero, no sign
            offset_magnitude <= lane4_ctrl[`LTG_BIT_OFFSET_MSB:`LTG_BIT_OFFSET_LSB];
            offset_positive <= !lane4_ctrl[`LTG_BIT_OFFSET_SIGN] &&
                               (lane4_ctrl[`LTG_BIT_OFFSET_MSB:`LTG_BIT_OFFSET_LSB] != 3'h0);
            offset_negative <= lane4_ctrl[`LTG_BIT_OFFSET_SIGN] &&
                               (lane4_ctrl[`LTG_BIT_OFFSET_MSB:`LTG_BIT_OFFSET_LSB] != 3'h0);
            // strap is only reported; the board is expected to tie it high
            swing_full <= strap_s;
        end
    end

endmodule // ltg_regs

// File: ltg_regs_asserts.sv
// ltg_regs_asserts.sv: port-level checks for the lane-four register slice.
// assumes: bound to ltg_regs; the host keeps scl low for at least 8 clk.
`timescale 1ns/1ns

// ****************
// checker
// ****************
module ltg_regs_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic swing_strap,
    input wire logic lane_sleep,
    input wire logic output_driver_off,
    input wire logic gain_medium,
    input wire logic gain_minimum,
    input wire logic offset_positive,
    input wire logic offset_negative,
    input wire logic [2:0] offset_magnitude,
    input wire logic swing_full
);
    logic [1:0] since_rst;

    // saturating count of edges since reset release
    always @(posedge clk or negedge rstn)
        if (!rstn)
            since_rst <= 2'h0;
        else if (since_rst != 2'h3)
            since_rst <= since_rst + 2'h1;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    chk_reset_clears: assert property (since_rst == 2'h1 |-> !sda_oe && !lane_sleep
        && !output_driver_off && !gain_medium && !gain_minimum && offset_magnitude == 3'h0)
        else $error("lane controls not clear after reset");
    // register moves only on the synced scl fall, so the decoded lane controls never change while scl is high
    chk_sleep_quiet: assert property ($changed(lane_sleep) |-> !scl_in)
        else $error("lane sleep changed with scl high");
    chk_driver_quiet: assert property ($changed(output_driver_off) |-> !$past(scl_in, 3))
        else $error("driver off changed too soon after scl fall");
    chk_gain_quiet: assert property ($changed({gain_medium, gain_minimum}) |-> !scl_in)
        else $error("gain select changed with scl high");
    chk_gain_excl: assert property (gain_medium |-> !gain_minimum)
        else $error("medium and minimum gain both set");
    chk_offset_excl: assert property (offset_positive |-> !offset_negative)
        else $error("positive and negative shift both set");
    chk_offset_zero: assert property ((offset_positive || offset_negative) ==
        (offset_magnitude != 3'h0))
        else $error("shift direction disagrees with magnitude");
    chk_ack_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
        else $error("sda drive changed outside scl low");
endmodule // ltg_regs_asserts

// File: ltg_host.sv
// ltg_host.sv: two-wire serial host driving the register slice.
// assumes: sda is resolved outside with a pull-up; all moves on falling clk.
`timescale 1ns/1ns

// ****************
// host bus cycles
// ****************
module ltg_host #(
    parameter logic [6:0] ADDR = 7'h00
) (
    input wire logic clk,
    output logic scl,
    output logic sda_lo,
    input wire logic sda
);
    initial
    begin
        scl = 1'b1;
        sda_lo = 1'b0;
    end

    // half bit time: covers the device's 2-flop pin sync and edge detect
    task hp;
        repeat (8) @(negedge clk);
    endtask

    task start_c;
        repeat (2) @(negedge clk);
        sda_lo = 1'b0;
        hp;
        scl = 1'b1;
        hp;
        sda_lo = 1'b1;
        hp;
        scl = 1'b0;
    endtask

    task stop_c;
        repeat (2) @(negedge clk);
        sda_lo = 1'b1;
        hp;
        scl = 1'b1;
        hp;
        sda_lo = 1'b0;
        hp;
    endtask

    // data moves 2 clk after scl fall so it never races the falling clock edge
    task bit_c(input logic drv_lo, output logic got);
        repeat (2) @(negedge clk);
        sda_lo = drv_lo;
        hp;
        scl = 1'b1;
        repeat (4) @(negedge clk);
        got = sda;
        repeat (4) @(negedge clk);
        scl = 1'b0;
    endtask

    task tx(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--)
            bit_c(~b[i], g);
        bit_c(1'b0, g);
        ack = ~g;
    endtask

    task rx(input logic last, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--)
        begin
            bit_c(1'b0, g);
            b[i] = g;
        end
        bit_c(~last, g);
    endtask

    task wr(input logic [7:0] off, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start_c;
        tx({ADDR, 1'b0}, a0);
        tx(off, a1);
        tx(d, a2);
        stop_c;
        ok = a0 & a1 & a2;
    endtask

    task rd(input logic [7:0] off, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start_c;
        tx({ADDR, 1'b0}, a0);
        tx(off, a1);
        start_c;
        tx({ADDR, 1'b1}, a2);
        rx(1'b1, d);
        stop_c;
        ok = a0 & a1 & a2;
    endtask
endmodule // ltg_host

// File: lane4_threshold_gain_regs_test.sv
// lane4_threshold_gain_regs_test.sv: self-checking bench for ltg_regs.
// assumes: ltg_host and ltg_regs_asserts are compiled alongside.
`timescale 1ns/1ns
`include "ltg_defs.vh"

// ****************
// bench
// ****************
module lane4_threshold_gain_regs_test;
    logic clk, rstn, swing_strap, scl, sda_lo, sda_out, sda_oe, swing_full;
    logic lane_sleep, output_driver_off, gain_medium, gain_minimum;
    logic offset_positive, offset_negative;
    logic [2:0] offset_magnitude;
    wire sda;
    int miscompares, n_compared;

    // pull-up on the open-drain data line
    assign sda = ~(sda_lo | sda_oe);

    ltg_host #(.ADDR(`LTG_DEV_ADDR)) u_host (.clk(clk), .scl(scl), .sda_lo(sda_lo), .sda(sda));
    ltg_regs #(.DEV_ADDR(`LTG_DEV_ADDR)) u_dut (.clk(clk), .rstn(rstn), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .swing_strap(swing_strap),
        .lane_sleep(lane_sleep), .output_driver_off(output_driver_off),
        .gain_medium(gain_medium), .gain_minimum(gain_minimum),
        .offset_positive(offset_positive), .offset_negative(offset_negative),
        .offset_magnitude(offset_magnitude), .swing_full(swing_full));

    initial clk = 1'b0;
    always #2 clk = ~clk;

    task chk(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function logic [8:0] lanes();
        lanes = {lane_sleep, output_driver_off, gain_medium, gain_minimum,
            offset_positive, offset_negative, offset_magnitude};
    endfunction

    function logic [8:0] decode(input logic [7:0] v);
        decode = {v[7], v[6], v[5:4] == 2'h2, v[5:4] == 2'h3,
            ~v[3] && v[2:0] != 3'h0, v[3] && v[2:0] != 3'h0, v[2:0]};
    endfunction

    task put(input logic [7:0] off, input logic [7:0] d);
        logic ok;
        u_host.wr(off, d, ok);
        chk({8'h00, ok}, 9'h001);
    endtask

    task get(input logic [7:0] off, input logic [7:0] exp);
        logic ok;
        logic [7:0] d;
        u_host.rd(off, d, ok);
        chk({ok, d}, {1'b1, exp});
    endtask

    task t_codes;
        logic [7:0] tbl [12];
        tbl = '{8'h80, 8'h40, 8'h10, 8'h20, 8'h30, 8'h01,
            8'h07, 8'h08, 8'h09, 8'h0F, 8'hFF, 8'h00};
        chk(lanes(), 9'h000);
        get(`LTG_OFF_LANE4_CTRL, `LTG_RST_LANE4_CTRL);
        foreach (tbl[i])
        begin
            put(`LTG_OFF_LANE4_CTRL, tbl[i]);
            repeat (2) @(negedge clk);
            chk(lanes(), decode(tbl[i]));
            get(`LTG_OFF_LANE4_CTRL, tbl[i]);
        end
    endtask

    task t_reserved;
        logic [7:0] rs [5];
        rs = '{`LTG_OFF_RSVD_A, `LTG_OFF_RSVD_B, `LTG_OFF_RSVD_C,
            `LTG_OFF_RSVD_D, `LTG_OFF_RSVD_E};
        put(`LTG_OFF_LANE4_CTRL, 8'h5A);
        foreach (rs[i])
        begin
            put(rs[i], 8'hFF);
            get(rs[i], `LTG_RST_RESERVED);
        end
        get(`LTG_OFF_LANE4_CTRL, 8'h5A);
        chk(lanes(), decode(8'h5A));
    endtask

    // a foreign address must leave the register alone
    task t_addr;
        logic a;
        u_host.start_c;
        u_host.tx({~`LTG_DEV_ADDR, 1'b0}, a);
        u_host.tx(`LTG_OFF_LANE4_CTRL, a);
        u_host.tx(8'h00, a);
        u_host.stop_c;
        chk({8'h00, a}, 9'h000);
        get(`LTG_OFF_LANE4_CTRL, 8'h5A);
    endtask

    // bursts step the offset: 13h is not held, 14h takes the second byte
    task t_burst;
        logic a0, a1, a2, a3;
        logic [7:0] d0, d1;
        u_host.start_c;
        u_host.tx({`LTG_DEV_ADDR, 1'b0}, a0);
        u_host.tx(8'h13, a1);
        u_host.tx(8'hEE, a2);
        u_host.tx(8'h3C, a3);
        u_host.stop_c;
        chk({5'h00, a0, a1, a2, a3}, 9'h00F);
        chk(lanes(), decode(8'h3C));
        u_host.start_c;
        u_host.tx({`LTG_DEV_ADDR, 1'b0}, a0);
        u_host.tx(8'h13, a1);
        u_host.start_c;
        u_host.tx({`LTG_DEV_ADDR, 1'b1}, a2);
        u_host.rx(1'b0, d0);
        u_host.rx(1'b1, d1);
        u_host.stop_c;
        chk({1'b0, d0}, 9'h000);
        chk({a2, d1}, 9'h13C);
        chk({8'h00, sda_out}, 9'h000);
    endtask

    task t_strap;
        swing_strap = 1'b0;
        repeat (6) @(negedge clk);
        chk({8'h00, swing_full}, 9'h000);
        swing_strap = 1'b1;
        repeat (6) @(negedge clk);
        chk({8'h00, swing_full}, 9'h001);
    endtask

    task t_midreset;
        put(`LTG_OFF_LANE4_CTRL, 8'hC3);
        rstn = 1'b0;
        repeat (3) @(negedge clk);
        chk(lanes(), 9'h000);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        get(`LTG_OFF_LANE4_CTRL, `LTG_RST_LANE4_CTRL);
    endtask

    task tally_and_finish;
        if (miscompares == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        miscompares = 0;
        n_compared = 0;
        rstn = 1'b0;
        swing_strap = 1'b1;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        t_codes;
        t_reserved;
        t_addr;
        t_burst;
        t_strap;
        t_midreset;
        tally_and_finish;
    end

    // the full run needs about 30k clk; 50k clk leaves a wide margin
    initial
    begin
        #200000;
        miscompares++;
        tally_and_finish;
    end
endmodule // lane4_threshold_gain_regs_test

bind ltg_regs ltg_regs_asserts u_chk (.clk(clk), .rstn(rstn), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .swing_strap(swing_strap),
    .lane_sleep(lane_sleep), .output_driver_off(output_driver_off),
    .gain_medium(gain_medium), .gain_minimum(gain_minimum),
    .offset_positive(offset_positive), .offset_negative(offset_negative),
    .offset_magnitude(offset_magnitude), .swing_full(swing_full));
